// >>> verilog/sprs_phase_range_select.v
// phase comparison with selectable span, update rate, limiter and hysteresis on the double and quad spans, plus apb control
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "sprs_regs.vh"
module sprs_phase_range_select (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// pins
	input wire crystal_clock_in,
	input wire speed_pulse_in,
	input wire span_select_low,
	input wire span_select_high,
	input wire ratio_select_a,
	input wire ratio_select_b,
	input wire ratio_select_c,
	// phase result
	output reg [7:0] phase_control_out,
	output reg phaseUpdate
);

	// ratio pins to divider ratio
	function [4:0] ratioOf;
		input [2:0] pins;
		begin
			case (pins)
				3'h7: ratioOf = 5'd20;
				3'h6: ratioOf = 5'd10;
				3'h5: ratioOf = 5'd6;
				3'h4: ratioOf = 5'd3;
				3'h3: ratioOf = 5'd2;
				3'h2: ratioOf = 5'd1;
				3'h1: ratioOf = 5'd2;
				default: ratioOf = 5'd1;
			endcase
		end
	endfunction

	// span code to reference periods covered
	function [2:0] periodsOf;
		input [1:0] span;
		begin
			case (span)
				`SPRS_SPAN_DOUBLE: periodsOf = `SPRS_PERIODS_DOUBLE;
				`SPRS_SPAN_QUAD: periodsOf = `SPRS_PERIODS_QUAD;
				default: periodsOf = `SPRS_PERIODS_STD;
			endcase
		end
	endfunction

	// span code to counted events between refreshes, less one
	function [1:0] eventsOf;
		input [1:0] span;
		begin
			case (span)
				`SPRS_SPAN_DOUBLE: eventsOf = 2'd1;
				`SPRS_SPAN_QUAD: eventsOf = 2'd3;
				default: eventsOf = 2'd0;
			endcase
		end
	endfunction

	// divider states
	localparam DV_IDLE = 1'b0;
	localparam DV_RUN = 1'b1;

	wire [2:0] ratioPins = {ratio_select_c, ratio_select_b, ratio_select_a};
	wire [4:0] ratio = ratioOf(ratioPins);
	wire fgDivide = (ratioPins == 3'h0) || (ratioPins == 3'h1);
	wire [11:0] refBase = fgDivide ? `SPRS_REF_BASE_HALF : `SPRS_REF_BASE_FULL;
	wire [16:0] refLen = ratio * refBase;
	wire [1:0] spanPins = {span_select_high, span_select_low};

	// software control and refresh counter
	reg [31:0] ctrl_reg;
	reg [15:0] updates_reg;

	// edge detectors start low, the idle level of both pins
	reg xtalPrev_reg;
	reg fgPrev_reg;
	reg fgToggle_reg;
	reg [16:0] refCnt_reg;
	reg signed [4:0] pending_reg;
	reg [1:0] evCnt_reg;
	reg [1:0] span_reg;
	reg dvState_reg;
	reg [3:0] dvStep_reg;
	reg [27:0] dvNum_reg;
	reg [27:0] dvDen_reg;
	reg [8:0] dvQuot_reg;

	wire enable = ctrl_reg[`SPRS_CTRL_EN_BIT];
	wire [3:0] hyst = ctrl_reg[`SPRS_CTRL_HYST_MSB:`SPRS_CTRL_HYST_LSB];
	wire xtalTick = crystal_clock_in & ~xtalPrev_reg;
	wire refWrap = xtalTick && (refCnt_reg >= refLen - 17'd1);
	wire fgEdge = speed_pulse_in & ~fgPrev_reg;
	// the halving stage passes every second FG edge, so the refresh rate halves for every span
	wire fgEvent = fgEdge && (!fgDivide || fgToggle_reg);
	wire testMode = (span_reg == `SPRS_SPAN_TEST);
	wire [1:0] evPerUpdate = eventsOf(span_reg);
	wire boundary = fgEvent && (evCnt_reg == evPerUpdate);
	wire [2:0] periods = periodsOf(span_reg);

	// limiter: unmatched reference edges saturate, so large slips pin the result at the span edge
	wire signed [4:0] pendHi = $signed({2'b00, periods}) + 5'sd1;
	wire signed [4:0] pendLo = -$signed({2'b00, periods});
	reg signed [4:0] pendNext;

	// lag of FG behind reference, in crystal ticks; positive means the FG edge came late
	wire signed [23:0] lagTicks = (pending_reg - 5'sd1) * $signed({1'b0, refLen}) +
		$signed({7'b0, refCnt_reg});
	wire [19:0] spanTicks = periods * refLen;
	wire signed [23:0] halfSpan = $signed({5'b0, spanTicks[19:1]});
	wire signed [23:0] numRaw = lagTicks + halfSpan;
	reg [19:0] numClamp;

	// second half of the limiter: a lag beyond the span pins the code at zero or full scale
	always @* begin
		numClamp = numRaw[19:0];
		if (numRaw[23]) begin
			numClamp = 20'd0;
		end else if (numRaw[22:0] > {3'b0, spanTicks}) begin
			numClamp = spanTicks;
		end
	end

	wire [27:0] dvTrial = dvDen_reg << (dvStep_reg - 4'd1);
	wire [7:0] dvCode = (dvQuot_reg > `SPRS_OUT_MAX) ? 8'hFF : dvQuot_reg[7:0];
	reg [7:0] outDiff;

	always @* begin
		if (dvCode > phase_control_out) begin
			outDiff = dvCode - phase_control_out;
		end else begin
			outDiff = phase_control_out - dvCode;
		end
	end
	wire useHyst = (span_reg == `SPRS_SPAN_DOUBLE) || (span_reg == `SPRS_SPAN_QUAD);
	wire outMoves = !useHyst || (outDiff > {4'b0, hyst});

	always @* begin
		pendNext = pending_reg;
		if (refWrap && !fgEvent) begin
			pendNext = (pending_reg >= pendHi) ? pendHi : pending_reg + 5'sd1;
		end else if (fgEvent && !refWrap) begin
			pendNext = (pending_reg <= pendLo) ? pendLo : pending_reg - 5'sd1;
		end
	end

	// reference generation and phase bookkeeping
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			xtalPrev_reg <= 1'b0;
			fgPrev_reg <= 1'b0;
			fgToggle_reg <= 1'b0;
			refCnt_reg <= 17'd0;
			pending_reg <= 5'sd1;
			evCnt_reg <= 2'd0;
			span_reg <= `SPRS_SPAN_STD;
		end else begin
			xtalPrev_reg <= crystal_clock_in;
			fgPrev_reg <= speed_pulse_in;
			if (fgEdge) begin
				fgToggle_reg <= ~fgToggle_reg;
			end
			if (refWrap) begin
				refCnt_reg <= 17'd0;
			end else if (xtalTick) begin
				refCnt_reg <= refCnt_reg + 17'd1;
			end
			pending_reg <= enable ? pendNext : 5'sd1;
			if (boundary) begin
				evCnt_reg <= 2'd0;
				// new span is taken only here so the events of one refresh share a span; the running divide's hysteresis test already sees the new span
				span_reg <= spanPins;
			end else if (fgEvent) begin
				evCnt_reg <= evCnt_reg + 2'd1;
			end
		end
	end

	// restoring divider scales the clamped lag onto the 8-bit output
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			dvState_reg <= DV_IDLE;
			dvStep_reg <= 4'd0;
			dvNum_reg <= 28'd0;
			dvDen_reg <= 28'd1;
			dvQuot_reg <= 9'd0;
			phase_control_out <= `SPRS_OUT_MID;
			phaseUpdate <= 1'b0;
			updates_reg <= 16'd0;
		end else begin
			phaseUpdate <= 1'b0;
			case (dvState_reg)
				DV_IDLE: begin
					if (!enable || testMode) begin
						phase_control_out <= `SPRS_OUT_MID;
					end else if (boundary) begin
						dvNum_reg <= {numClamp, 8'h00};
						dvDen_reg <= {8'h00, spanTicks};
						dvQuot_reg <= 9'd0;
						dvStep_reg <= `SPRS_DIV_STEPS;
						dvState_reg <= DV_RUN;
					end
				end
				DV_RUN: begin
					if (dvStep_reg == 4'd0) begin
						dvState_reg <= DV_IDLE;
						if (outMoves) begin
							phase_control_out <= dvCode;
						end
						phaseUpdate <= 1'b1;
						// counter wraps silently; software compares differences
						updates_reg <= updates_reg + 16'd1;
					end else begin
						if (dvNum_reg >= dvTrial) begin
							dvNum_reg <= dvNum_reg - dvTrial;
							dvQuot_reg <= dvQuot_reg | (9'd1 << (dvStep_reg - 4'd1));
						end
						dvStep_reg <= dvStep_reg - 4'd1;
					end
				end
				default: begin
					dvState_reg <= DV_IDLE;
				end
			endcase
		end
	end

	// apb slave, one wait state on every access
	wire apbAccess = psel && penable;
	wire apbDone = apbAccess && pready;
	wire mapped = (paddr == `SPRS_ADDR_CTRL) || (paddr == `SPRS_ADDR_STATUS) ||
		(paddr == `SPRS_ADDR_UPDATES);
	reg [31:0] readMux;

	always @* begin
		readMux = 32'h0000_0000;
		case (paddr)
			`SPRS_ADDR_CTRL: readMux = ctrl_reg;
			`SPRS_ADDR_STATUS: begin
				readMux[`SPRS_ST_SPAN_MSB:`SPRS_ST_SPAN_LSB] = span_reg;
				readMux[`SPRS_ST_TEST_BIT] = testMode;
				readMux[`SPRS_ST_FGDIV_BIT] = fgDivide;
				readMux[`SPRS_ST_RATIO_MSB:`SPRS_ST_RATIO_LSB] = ratio;
				readMux[`SPRS_ST_OUT_MSB:`SPRS_ST_OUT_LSB] = phase_control_out;
			end
			`SPRS_ADDR_UPDATES: readMux = {16'h0000, updates_reg};
			default: readMux = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_reg <= `SPRS_CTRL_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			if (apbAccess && !pready) begin
				pready <= 1'b1;
				pslverr <= !mapped;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
			if (apbAccess && !pready && !pwrite) begin
				prdata <= readMux;
			end else begin
				// read data stands only in the ready cycle so no stale word lingers on the bus
				prdata <= 32'h0000_0000;
			end
			if (apbDone && pwrite && paddr == `SPRS_ADDR_CTRL) begin
				// only enable and hysteresis bits exist; the rest read back as zero
				ctrl_reg <= pwdata & 32'h0000_0F01;
			end
		end
	end

endmodule

// >>> verilog/sprs_regs.vh
// register map, field positions, reset values and fixed counts of the phase range select block
`ifndef SPRS_REGS_VH
`define SPRS_REGS_VH
`define SPRS_ADDR_CTRL 12'h000
`define SPRS_ADDR_STATUS 12'h004
`define SPRS_ADDR_UPDATES 12'h008
`define SPRS_CTRL_EN_BIT 0
`define SPRS_CTRL_HYST_LSB 8
`define SPRS_CTRL_HYST_MSB 11
`define SPRS_CTRL_RESET 32'h0000_0201
`define SPRS_ST_SPAN_LSB 0
`define SPRS_ST_SPAN_MSB 1
`define SPRS_ST_TEST_BIT 2
`define SPRS_ST_FGDIV_BIT 3
`define SPRS_ST_RATIO_LSB 4
`define SPRS_ST_RATIO_MSB 8
`define SPRS_ST_OUT_LSB 16
`define SPRS_ST_OUT_MSB 23
`define SPRS_SPAN_STD 2'h0
`define SPRS_SPAN_TEST 2'h1
`define SPRS_SPAN_DOUBLE 2'h2
`define SPRS_SPAN_QUAD 2'h3
`define SPRS_PERIODS_STD 3'h1
`define SPRS_PERIODS_DOUBLE 3'h3
`define SPRS_PERIODS_QUAD 3'h7
`define SPRS_REF_BASE_FULL 12'h802
`define SPRS_REF_BASE_HALF 12'h401
`define SPRS_OUT_MID 8'h80
`define SPRS_OUT_MAX 9'h0FF
`define SPRS_DIV_STEPS 4'h9
`endif

// >>> tb/sprs_monitor.sv
// checker for the phase range select block ports
`timescale 1ns/1ps
module sprs_monitor (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// phase result
	input wire [7:0] phase_control_out,
	input wire phaseUpdate
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	readyTime_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("ready did not follow one wait state");
	readyPulse_a: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	errReady_a: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	errDecode_a: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h008))
		else $error("error flag does not match address");
	readIdle_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data not cleared");
	// midscale may be forced without a refresh by test mode or disable
	outChange_a: assert property (phase_control_out != $past(phase_control_out) |-> phaseUpdate || phase_control_out == 8'h80)
		else $error("phase output moved without refresh");
	updPulse_a: assert property (phaseUpdate |=> !phaseUpdate)
		else $error("refresh pulse too long");
	resetOut_a: assert property ($past(sys_rst) |-> phase_control_out == 8'h80 && !phaseUpdate && !pready)
		else $error("reset state wrong");
	cover property (phaseUpdate);
	cover property (pready && pslverr);
	cover property (pready && pwrite);
endmodule
bind sprs_phase_range_select sprs_monitor u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.phase_control_out(phase_control_out), .phaseUpdate(phaseUpdate));

// >>> tb/sprs_fg_encoder.sv
// motor encoder model: bursts of fg pulses, 4 clocks high and 36 low
`timescale 1ns/1ps
module sprs_fg_encoder (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// burst request
	input wire go,
	input wire [3:0] count,
	// encoder side
	output reg speed_pulse_in,
	output reg busy
);
	reg [3:0] left_reg;
	reg [5:0] tick_reg;
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			left_reg <= 4'h0;
			tick_reg <= 6'h00;
			speed_pulse_in <= 1'b0;
			busy <= 1'b0;
		end else if (go && !busy) begin
			left_reg <= count;
			tick_reg <= 6'h00;
			busy <= 1'b1;
		end else if (busy) begin
			tick_reg <= (tick_reg == 6'd39) ? 6'h00 : tick_reg + 6'h01;
			// a real encoder line rests low between pulses
			speed_pulse_in <= (tick_reg < 6'd4) && (left_reg != 4'h0);
			if (tick_reg == 6'd39) begin
				left_reg <= left_reg - 4'h1;
				busy <= (left_reg != 4'h1);
			end
		end
	end
endmodule

// >>> tb/sprs_tb.sv
// testbench: apb tasks, encoder bursts, ratio decode and span table
`timescale 1ns/1ps
module tb;
	reg clk_sys, sys_rst, psel, penable, pwrite, go, e;
	reg [11:0] paddr;
	reg [31:0] pwdata, rd, u0;
	reg [2:0] ratioPins;
	reg [1:0] spanPins, xtal_reg;
	reg [3:0] cnt;
	reg [4:0] ratioTab [0:7];
	reg [17:0] rowTab [0:6];
	wire [31:0] prdata;
	wire [7:0] phase_control_out;
	wire pready, pslverr, phaseUpdate, fgPulse, busy;
	integer errCount, testsRun, i, k;
	sprs_phase_range_select dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.crystal_clock_in(xtal_reg[1]), .speed_pulse_in(fgPulse), .span_select_low(spanPins[0]),
		.span_select_high(spanPins[1]), .ratio_select_a(ratioPins[0]), .ratio_select_b(ratioPins[1]),
		.ratio_select_c(ratioPins[2]), .phase_control_out(phase_control_out), .phaseUpdate(phaseUpdate));
	sprs_fg_encoder fg (.clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .count(cnt), .speed_pulse_in(fgPulse),
		.busy(busy));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// crystal at a quarter of the system clock keeps ticks well below clk/2
	always @(posedge clk_sys) xtal_reg <= xtal_reg + 2'b01;
	task finalReport;
		begin
			$display("counts: %0d compares, %0d mismatches", testsRun, errCount);
			if (errCount == 0 && testsRun > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	task timeout;
		begin
			errCount = errCount + 1;
			finalReport;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			testsRun = testsRun + 1;
			if (got !== exp) begin
				errCount = errCount + 1;
				$display("ERROR at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk_sys);
			penable <= 1'b1;
			k = 0;
			@(posedge clk_sys);
			while (pready !== 1'b1 && k < 20) begin
				@(posedge clk_sys);
				k = k + 1;
			end
			rd = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			if (k >= 20) timeout;
			@(posedge clk_sys);
		end
	endtask
	task burst(input [3:0] n);
		begin
			cnt <= n;
			go <= 1'b1;
			@(posedge clk_sys);
			go <= 1'b0;
			@(posedge clk_sys);
			k = 0;
			while (busy !== 1'b0 && k < 1000) begin
				@(posedge clk_sys);
				k = k + 1;
			end
			if (k >= 1000) timeout;
			repeat (15) @(posedge clk_sys);
		end
	endtask
	initial begin
		errCount = 0;
		testsRun = 0;
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		go = 1'b0;
		cnt = 4'h0;
		xtal_reg = 2'b00;
		spanPins = 2'b00;
		ratioPins = 3'b010;
		ratioTab[0] = 5'd1; ratioTab[1] = 5'd2; ratioTab[2] = 5'd1; ratioTab[3] = 5'd2;
		ratioTab[4] = 5'd3; ratioTab[5] = 5'd6; ratioTab[6] = 5'd10; ratioTab[7] = 5'd20;
		// fields: span pins {high,low}, ratio pins, enable, refreshes per 8 pulses, final code
		rowTab[0] = {2'b00, 3'b010, 1'b1, 4'h8, 8'h00};
		rowTab[1] = {2'b10, 3'b010, 1'b1, 4'h4, 8'h00};
		rowTab[2] = {2'b11, 3'b010, 1'b1, 4'h2, 8'h00};
		rowTab[3] = {2'b01, 3'b010, 1'b1, 4'h0, 8'h80};
		rowTab[4] = {2'b00, 3'b010, 1'b0, 4'h0, 8'h80};
		rowTab[5] = {2'b11, 3'b000, 1'b1, 4'h1, 8'h00};
		rowTab[6] = {2'b00, 3'b000, 1'b1, 4'h4, 8'h00};
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		chk({24'h00_0000, phase_control_out}, 32'h0000_0080);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd, 32'h0000_0201);
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk({e, rd[30:0]}, 32'h8000_0000);
		$display("test reset and map done");
		for (i = 0; i < 8; i = i + 1) begin
			ratioPins <= i[2:0];
			repeat (3) @(posedge clk_sys);
			apb(1'b0, 12'h004, 32'h0000_0000);
			chk({26'h000_0000, rd[8:3]}, {26'h000_0000, ratioTab[i], i < 2});
		end
		$display("test ratio decode done");
		for (i = 0; i < 7; i = i + 1) begin
			{spanPins, ratioPins} <= rowTab[i][17:13];
			apb(1'b1, 12'h000, {31'h0000_0100, rowTab[i][12]});
			// a long first burst drives the slip counter to its limit before the measured burst
			burst(4'hF);
			apb(1'b0, 12'h008, 32'h0000_0000);
			u0 = rd;
			burst(4'h8);
			apb(1'b0, 12'h008, 32'h0000_0000);
			chk({16'h0000, rd[15:0] - u0[15:0]}, {28'h000_0000, rowTab[i][11:8]});
			chk({24'h00_0000, phase_control_out}, {24'h00_0000, rowTab[i][7:0]});
			$display("test span row %0d done", i);
		end
		// three halved reference periods with no pulse leave the encoder lagging
		repeat (14000) @(posedge clk_sys);
		burst(4'h2);
		chk({24'h00_0000, phase_control_out}, 32'h0000_00FF);
		$display("test lagging encoder done");
		finalReport;
	end
endmodule
